// ### bpgpio_pkg.sv
// package: register map, reset values and field layout of the byte port
package bpgpio_pkg;
    // word indices of the three registers (low 20 bits); each register owns
    // one aligned 32-bit word, so its byte address is four times its index
    localparam logic [19:0] BPGPIO_PIN_DIRECTION_IDX    = 20'hee003;
    localparam logic [19:0] BPGPIO_PULLUP_ENABLE_IDX    = 20'hee03e;
    localparam logic [19:0] BPGPIO_PIN_OUTPUT_DATA_IDX  = 20'hfffd3;
    localparam logic [21:0] BPGPIO_PIN_DIRECTION_ADDR   = {BPGPIO_PIN_DIRECTION_IDX, 2'b00};
    localparam logic [21:0] BPGPIO_PULLUP_ENABLE_ADDR   = {BPGPIO_PULLUP_ENABLE_IDX, 2'b00};
    localparam logic [21:0] BPGPIO_PIN_OUTPUT_DATA_ADDR = {BPGPIO_PIN_OUTPUT_DATA_IDX, 2'b00};
    // reset values
    localparam logic [7:0]  BPGPIO_PIN_DIRECTION_RST    = 8'h00;
    localparam logic [7:0]  BPGPIO_PULLUP_ENABLE_RST    = 8'h00;
    localparam logic [7:0]  BPGPIO_PIN_OUTPUT_DATA_RST  = 8'h00;
    // field layout
    localparam int          BPGPIO_PINS                 = 8;
    localparam int          BPGPIO_AREAS                = 8;
    localparam logic [31:0] BPGPIO_RD_ZERO              = 32'h0000_0000;
    // write-only direction register reads back as this value
    localparam logic [7:0]  BPGPIO_WO_READ_VAL          = 8'h00;
endpackage : bpgpio_pkg

// ### bpgpio_sync2.sv
// two-flop synchroniser for the eight pin inputs
`timescale 1ns/1ns
`default_nettype none
module bpgpio_sync2
    import bpgpio_pkg::*;
#(
    parameter int W = 8
)(
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } bpgpio_sync_t;

    bpgpio_sync_t st_r;
    bpgpio_sync_t st_nxt;

    // second flop alone reads the first
    always_comb
    begin
        st_nxt.meta = async_in;
        st_nxt.stab = st_r.meta;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign sync_out = st_r.stab;
endmodule : bpgpio_sync2
`default_nettype wire

// ### bpgpio_pad.sv
// one pad slice: selects bus or port drive and the pull-up for one pin
`timescale 1ns/1ns
`default_nettype none
module bpgpio_pad
    import bpgpio_pkg::*;
(
    input  wire logic bus16,
    input  wire logic hw_standby,
    input  wire logic dir,
    input  wire logic dout,
    input  wire logic pu_en,
    input  wire logic bus_oe,
    input  wire logic bus_out,
    output logic      pin_oe,
    output logic      pin_out,
    output logic      pin_pullup
);
    // wide bus owns the pin whatever the direction bit holds
    always_comb
    begin
        if (bus16)
        begin
            pin_oe  = bus_oe;
            pin_out = bus_out;
        end
        else
        begin
            pin_oe  = dir & ~hw_standby;
            pin_out = dout;
        end
        // pull-up only on narrow-bus inputs, off in hardware standby
        pin_pullup = ~bus16 & ~hw_standby & ~dir & pu_en;
    end
endmodule : bpgpio_pad
`default_nettype wire

// ### bpgpio_top.sv
// byte port: eight-pin general-purpose i/o shared with the upper data bus
//
// Contract
// - port is gpio only when all areas 8-bit
// - 16-bit mode: pins carry bus regardless direction
// - 8-bit mode: direction 1 drives, 0 inputs
// - direction register eight bits, write only
// - direction clears on reset, hardware standby
// - width config, direction kept in software standby
// - output pins keep driving in software standby
// - data register read/write, drives output pins
// - read gives data bit or live pin
// - data register clears reset, hardware standby only
// - pull-up on when enable 1, direction 0
// - pull-up register read/write, clears like others
// - pull-ups off in reset, hardware standby, 16-bit
`timescale 1ns/1ns
`default_nettype none
module bpgpio_top
    import bpgpio_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    arst_n,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [21:0]             paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // system state from the bus controller and power control
    input  wire logic [BPGPIO_AREAS-1:0] area_width_config,
    input  wire logic                    hw_standby,
    input  wire logic                    sw_standby,
    input  wire logic [BPGPIO_PINS-1:0]  bus_data_oe,
    input  wire logic [BPGPIO_PINS-1:0]  bus_data_out,
    output logic      [BPGPIO_PINS-1:0]  bus_data_in,
    output logic                         bus16_mode,
    // pins
    input  wire logic [BPGPIO_PINS-1:0]  pin_in,
    output logic      [BPGPIO_PINS-1:0]  pin_out,
    output logic      [BPGPIO_PINS-1:0]  pin_oe,
    output logic      [BPGPIO_PINS-1:0]  pin_pullup
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // all register state lives in one word so that reset and standby
    // clear it in one place; rdata and err are the bus answer prepared
    // in the setup cycle, so the access cycle needs no wait state
    typedef struct packed {
        logic [7:0]  pin_direction;
        logic [7:0]  pin_output_data;
        logic [7:0]  pullup_enable;
        logic [31:0] rdata;
        logic        err;
    } bpgpio_state_t;

    bpgpio_state_t st_r;
    bpgpio_state_t st_nxt;

    logic [BPGPIO_PINS-1:0] pin_sync;
    logic                   hit_dir;
    logic                   hit_pu;
    logic                   hit_dat;
    logic                   hit_any;
    logic                   acc;
    logic [7:0]             port_read;

    // ----------------------------------------------------------------
    // pin input synchroniser
    // ----------------------------------------------------------------
    bpgpio_sync2 #(.W(BPGPIO_PINS)) u_sync (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // pin levels arrive two cycles late; a read just after a far-side
    // change may still show the old level, which software must allow for
    // any 16-bit area turns the port into the upper data bus
    assign bus16_mode  = |area_width_config;
    assign bus_data_in = pin_sync;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign hit_dir = (paddr == BPGPIO_PIN_DIRECTION_ADDR);
    assign hit_pu  = (paddr == BPGPIO_PULLUP_ENABLE_ADDR);
    assign hit_dat = (paddr == BPGPIO_PIN_OUTPUT_DATA_ADDR);
    // one wait-free access phase; answer comes in the access cycle
    assign acc     = psel & penable;

    // register map, word aligned: each register owns one 32-bit word and
    // only bits 7:0 carry state; the upper bits read zero, ignore writes.
    //   pin_direction   write only, reads back a fixed value
    //   pullup_enable   read/write
    //   pin_output_data read/write, reads mix stored bits and live pins
    // any other word completes with pslverr and no effect, so a stray
    // pointer cannot disturb the port.
    // only lane 0 holds state, so pstrb[0] alone gates a write; a write
    // with lane 0 off is a legal no-op
    assign hit_any = hit_dir | hit_pu | hit_dat;

    // outputs pins hold their stored bit, inputs show the live level
    assign port_read = (st_r.pin_direction & st_r.pin_output_data)
                     | (~st_r.pin_direction & pin_sync);

    // register next state; setup cycle samples read data
    always_comb
    begin
        st_nxt = st_r;
        if (hw_standby)
        begin
            // hardware standby clears, software standby does not
            st_nxt.pin_direction   = BPGPIO_PIN_DIRECTION_RST;
            st_nxt.pin_output_data = BPGPIO_PIN_OUTPUT_DATA_RST;
            st_nxt.pullup_enable   = BPGPIO_PULLUP_ENABLE_RST;
        end
        else if (acc && pwrite && pstrb[0])
        begin
            // sw_standby deliberately absent: contents are kept
            if (hit_dir)
                st_nxt.pin_direction = pwdata[7:0];
            if (hit_dat)
                st_nxt.pin_output_data = pwdata[7:0];
            if (hit_pu)
                st_nxt.pullup_enable = pwdata[7:0];
        end
        // read data prepared in the setup cycle, stable in access phase
        if (psel && !penable)
        begin
            st_nxt.err   = ~(hit_dir | hit_pu | hit_dat);
            st_nxt.rdata = BPGPIO_RD_ZERO;
            if (!pwrite)
            begin
                if (hit_dat)
                    st_nxt.rdata[7:0] = port_read;
                else if (hit_pu)
                    st_nxt.rdata[7:0] = st_r.pullup_enable;
                else if (hit_dir)
                    st_nxt.rdata[7:0] = BPGPIO_WO_READ_VAL;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r                 <= '0;
            st_r.pin_direction   <= BPGPIO_PIN_DIRECTION_RST;
            st_r.pin_output_data <= BPGPIO_PIN_OUTPUT_DATA_RST;
            st_r.pullup_enable   <= BPGPIO_PULLUP_ENABLE_RST;
        end
        else
            st_r <= st_nxt;
    end

    assign prdata  = st_r.rdata;
    assign pready  = 1'b1;
    assign pslverr = acc & st_r.err;

    // ----------------------------------------------------------------
    // pad slices
    // ----------------------------------------------------------------
    // each slice chooses between bus controller and port registers; the
    // choice is combinational so a change of bus width takes effect at
    // once, with no cycle in which the old owner still drives the pin
    genvar g;
    generate
        for (g = 0; g < BPGPIO_PINS; g++)
        begin : g_pad
            // sw_standby does not reach the pad, so outputs keep driving
            bpgpio_pad u_pad (
                .bus16      (bus16_mode),
                .hw_standby (hw_standby),
                .dir        (st_r.pin_direction[g]),
                .dout       (st_r.pin_output_data[g]),
                .pu_en      (st_r.pullup_enable[g]),
                .bus_oe     (bus_data_oe[g]),
                .bus_out    (bus_data_out[g]),
                .pin_oe     (pin_oe[g]),
                .pin_out    (pin_out[g]),
                .pin_pullup (pin_pullup[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // ----------------------------------------------------------------
    // pin control
    // ----------------------------------------------------------------
    // any 16-bit area makes the port part of the data bus
    a_mode_decode: assert property (
        bus16_mode == (area_width_config != '0))
        else $error("bus width decode wrong");

    // wide bus: the controller owns enable and level of every pin
    a_bus_owns_pins: assert property (
        bus16_mode |-> (pin_oe == bus_data_oe && pin_out == bus_data_out))
        else $error("bus mode pins not following bus");

    // narrow bus outside hardware standby: each direction bit alone decides whether its pin drives
    a_gpio_dir_oe: assert property (
        !bus16_mode && !hw_standby |-> pin_oe == st_r.pin_direction)
        else $error("gpio enable differs from direction");

    // narrow bus: the pin level is the stored data bit
    a_gpio_data_out: assert property (
        !bus16_mode |-> pin_out == st_r.pin_output_data)
        else $error("gpio output differs from data");

    // ----------------------------------------------------------------
    // pull-ups
    // ----------------------------------------------------------------
    // on only for a narrow-bus input whose control bit is set
    a_pullup_gate: assert property (
        pin_pullup == ({8{~bus16_mode & ~hw_standby}} & ~st_r.pin_direction & st_r.pullup_enable))
        else $error("pull-up wrong");

    // the wide bus never sees a pull-up, in standby or not
    a_pullup_bus16: assert property (
        bus16_mode |-> pin_pullup == 8'h00)
        else $error("pull-up on in bus mode");

    // in narrow-bus mode hardware standby releases the pins and drops every pull-up at once
    a_hws_pins_off: assert property (
        hw_standby && !bus16_mode |-> pin_oe == 8'h00 && pin_pullup == 8'h00)
        else $error("pins not released in hardware standby");

    // ----------------------------------------------------------------
    // standby
    // ----------------------------------------------------------------
    // hardware standby wipes all three registers by the next edge
    a_hws_clears: assert property (
        hw_standby |=> (st_r.pin_direction == 8'h00 && st_r.pin_output_data == 8'h00
                        && st_r.pullup_enable == 8'h00))
        else $error("hardware standby did not clear");

    // software standby alone never touches the registers
    a_sws_keeps: assert property (
        sw_standby && !hw_standby && !(acc && pwrite) |=> $stable(st_r.pin_direction)
        && $stable(st_r.pin_output_data) && $stable(st_r.pullup_enable))
        else $error("software standby changed registers");

    // output pins go on driving their data through software standby
    a_sws_drive: assert property (
        sw_standby && !hw_standby && !bus16_mode
        |-> pin_oe == st_r.pin_direction && pin_out == st_r.pin_output_data)
        else $error("output dropped in software standby");

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // a write lands at the end of its access cycle
    a_dir_write: assert property (
        acc && pwrite && pstrb[0] && hit_dir && !hw_standby
        |=> st_r.pin_direction == $past(pwdata[7:0]))
        else $error("direction write lost");

    a_dat_write: assert property (
        acc && pwrite && pstrb[0] && hit_dat && !hw_standby
        |=> st_r.pin_output_data == $past(pwdata[7:0]))
        else $error("data write lost");

    a_pu_write: assert property (
        acc && pwrite && pstrb[0] && hit_pu && !hw_standby
        |=> st_r.pullup_enable == $past(pwdata[7:0]))
        else $error("pull-up write lost");

    a_strb_ignored: assert property (
        acc && pwrite && !pstrb[0] && !hw_standby |=> $stable(st_r.pin_direction)
        && $stable(st_r.pin_output_data) && $stable(st_r.pullup_enable))
        else $error("write without lane 0 changed a register");

    // ----------------------------------------------------------------
    // bus answers
    // ----------------------------------------------------------------
    // only unmapped words are refused
    a_unmapped_err: assert property (
        acc && !hit_any |-> pslverr)
        else $error("unmapped access not refused");

    a_mapped_ok: assert property (
        acc && hit_any |-> !pslverr)
        else $error("mapped access refused");

    // data read: stored bit for outputs, synchronised level for inputs
    a_read_mix: assert property (
        psel && !penable && !pwrite && hit_dat |=> prdata[7:0] == $past(port_read))
        else $error("port read wrong");

    // the write-only register reads back a fixed value
    a_dir_read_fixed: assert property (
        psel && !penable && !pwrite && hit_dir |=> prdata == {24'h00_0000, BPGPIO_WO_READ_VAL})
        else $error("direction read not fixed");

    a_pu_readback: assert property (
        psel && !penable && !pwrite && hit_pu |=> prdata[7:0] == $past(st_r.pullup_enable))
        else $error("pull-up read wrong");

    // registers are one byte wide, the rest of the word reads zero
    a_rd_upper_zero: assert property (
        prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");

    // ----------------------------------------------------------------
    // per-pin checks: a failure names the slice at fault
    // ----------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < BPGPIO_PINS; k++)
        begin : g_pin_chk
            // a driving pin never carries a pull-up as well
            a_pin_no_pu_drive: assert property (
                !bus16_mode && pin_oe[k] |-> !pin_pullup[k])
                else $error("pull-up on a driving pin");
            // a narrow-bus input follows its own control bit
            a_pin_pu_input: assert property (
                !bus16_mode && !hw_standby && !st_r.pin_direction[k] |-> pin_pullup[k] == st_r.pullup_enable[k])
                else $error("input pull-up differs from control bit");
            // a driving pin shows its own stored bit
            a_pin_drives_bit: assert property (
                !bus16_mode && pin_oe[k] |-> pin_out[k] == st_r.pin_output_data[k])
                else $error("driving pin shows wrong bit");
        end
    endgenerate

    // main scenarios worth seeing at least once
    c_dat_write: cover property (acc && pwrite && hit_dat);
    c_port_read: cover property (acc && !pwrite && hit_dat);
    c_bus16:     cover property (bus16_mode && |bus_data_oe);
    c_sws_drive: cover property (sw_standby && |pin_oe && !bus16_mode);
    c_hws_clear: cover property (hw_standby && st_r.pin_direction != 8'h00);
endmodule : bpgpio_top
`default_nettype wire

// ### bpgpio_pins_model.sv
// partner model: far-side pin drivers, pull-up and floating pins
`timescale 1ns/1ns
`default_nettype none
module bpgpio_pins_model
    import bpgpio_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_pullup,
    input  wire logic [7:0] ext_drv,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_in
);
    logic [7:0] float_r = 8'h55;
    // a floating pin wanders every cycle, so a stale level never passes
    always @(posedge sys_clk)
        float_r <= ~float_r;
    // wired level: own driver, far driver, pull-up, else floating
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
                  | (~pin_oe & ~ext_drv & (pin_pullup | float_r));
endmodule : bpgpio_pins_model
`default_nettype wire

// ### tb.sv
// testbench: random register and pin traffic for the byte port
`timescale 1ns/1ns
`default_nettype none
module tb;
    import bpgpio_pkg::*;
    logic sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic hw_standby = 1'b0, sw_standby = 1'b0, pready, pslverr, bus16_mode, err;
    logic [21:0] paddr = 22'h000000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'h0, strb = 4'h1;
    logic [7:0]  awc = 8'h00, bdoe = 8'h00, bdout = 8'h00, bdin, pin_in, pin_out, pin_oe, pin_pullup;
    logic [7:0]  xd = 8'hff, xv = 8'h00, dir, pu, dat;
    int mismatches = 0, checks = 0, cyc = 0;
    bpgpio_top bpgpio_top_inst (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .area_width_config(awc), .hw_standby(hw_standby),
        .sw_standby(sw_standby), .bus_data_oe(bdoe), .bus_data_out(bdout), .bus_data_in(bdin),
        .bus16_mode(bus16_mode), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup));
    bpgpio_pins_model bpgpio_pins_model_inst (.sys_clk(sys_clk), .pin_oe(pin_oe),
        .pin_out(pin_out), .pin_pullup(pin_pullup), .ext_drv(xd), .ext_val(xv), .pin_in(pin_in));
    // ------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------
    always #5 sys_clk = ~sys_clk;
    // a hang counts as a mismatch and ends the run
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer; idle edge first so psel is never set twice in a step
    task automatic apb(input logic wr, input logic [21:0] a, input logic [7:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        pstrb <= strb;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // expected level of a pin as the design should see it
    function automatic logic [7:0] lvl(input logic [7:0] oe, input logic [7:0] o);
        return (oe & o) | (~oe & ((xd & xv) | ~xd));
    endfunction : lvl
    task automatic pins(input logic [7:0] d, input logic [7:0] p, input logic [7:0] v);
        logic b;
        logic [7:0] eo;
        b = |awc;
        eo = b ? bdoe : d;
        check(bus16_mode, b);
        check(pin_oe, eo);
        check(pin_out & eo, (b ? bdout : v) & eo);
        check(pin_pullup, b ? 8'h00 : p & ~d);
    endtask : pins
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h4edf6036));
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        pins(8'h00, 8'h00, 8'h00);
        apb(1'b0, BPGPIO_PULLUP_ENABLE_ADDR, 8'h00);
        check(rd, 32'h0);
        for (int i = 0; i < 24; i++)
        begin
            dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            pu = (i == 0) ? 8'hff : 8'($urandom);
            dat = 8'($urandom);
            xv <= 8'($urandom);
            xd <= ~pu | 8'($urandom); // undriven pins rely on the pull-up
            awc <= 8'h00;
            sw_standby <= i[0]; // standby must change nothing
            apb(1'b1, BPGPIO_PIN_DIRECTION_ADDR, dir);
            apb(1'b1, BPGPIO_PULLUP_ENABLE_ADDR, pu);
            apb(1'b1, BPGPIO_PIN_OUTPUT_DATA_ADDR, dat);
            apb(1'b0, BPGPIO_PIN_DIRECTION_ADDR, 8'h00);
            check(rd, {24'h0, BPGPIO_WO_READ_VAL});
            apb(1'b0, BPGPIO_PULLUP_ENABLE_ADDR, 8'h00);
            check(rd, {24'h0, pu});
            apb(1'b0, BPGPIO_PIN_OUTPUT_DATA_ADDR, 8'h00);
            check(rd, {24'h0, (dir & dat) | (~dir & lvl(8'h00, 8'h00))});
            pins(dir, pu, dat);
            // wide bus takes the pins over, whatever the direction bits say
            awc <= 8'h01 << (i % 8);
            bdoe <= 8'($urandom);
            bdout <= 8'($urandom);
            xd <= 8'hff;
            repeat (4) @(posedge sys_clk);
            pins(dir, pu, dat);
            check(bdin, lvl(bdoe, bdout));
            awc <= 8'h00;
            @(posedge sys_clk);
            pins(dir, pu, dat);
        end
        // the word just past the direction register is unmapped
        apb(1'b1, 22'h3b8010, 8'hff);
        check(err, 1'b1);
        apb(1'b0, 22'h3b8010, 8'h00);
        check(rd, 32'h0);
        hw_standby <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check({pin_oe, pin_pullup}, 16'h0);
        hw_standby <= 1'b0;
        @(posedge sys_clk);
        pins(8'h00, 8'h00, 8'h00);
        apb(1'b0, BPGPIO_PULLUP_ENABLE_ADDR, 8'h00);
        check(rd, 32'h0);
        apb(1'b1, BPGPIO_PIN_DIRECTION_ADDR, 8'hff);
        apb(1'b0, BPGPIO_PIN_OUTPUT_DATA_ADDR, 8'h00);
        check(rd, 32'h0);
        // a write with byte lane 0 off must leave the data untouched
        apb(1'b1, BPGPIO_PIN_OUTPUT_DATA_ADDR, 8'h5a);
        strb = 4'h0;
        apb(1'b1, BPGPIO_PIN_OUTPUT_DATA_ADDR, 8'ha5);
        strb = 4'h1;
        apb(1'b0, BPGPIO_PIN_OUTPUT_DATA_ADDR, 8'h00);
        check(rd, 32'h5a);
        // mid-run reset clears what software wrote
        apb(1'b1, BPGPIO_PULLUP_ENABLE_ADDR, 8'hff);
        arst_n <= 1'b0;
        @(posedge sys_clk);
        arst_n <= 1'b1;
        apb(1'b0, BPGPIO_PULLUP_ENABLE_ADDR, 8'h00);
        check(rd, 32'h0);
        pins(8'h00, 8'h00, 8'h00);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
